// >>> bench/pmbus_bank_properties.sv
`timescale 1ns/1ps
`include "pmbus_bank_defs.svh"
module pmbus_bank_properties
  import pmbus_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire bus_req_t req_i,
  input wire bus_rsp_t rsp_o,
  input wire logic [7:0] page_i,
  input wire logic mem_fault_i,
  input wire logic comm_fault_i,
  input wire logic [15:0] input_voltage_i,
  input wire logic [`NVM_ADDR_W-1:0] nvm_addr_o,
  input wire logic [15:0] nvm_wdata_o,
  input wire logic nvm_wr_o,
  input wire logic nvm_erase_o,
  input wire logic [15:0] alt_cmd_o,
  input wire logic [15:0] channel_config_o,
  input wire logic [15:0] global_config_o,
  input wire logic [3:0] shared_fault_pin_o,
  input wire logic [`NUM_CHANNELS-1:0] faulted_off_i,
  input wire logic [3:0] shared_fault_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rev;
    req_i.rd && req_i.cmd == `CMD_PROTOCOL_REV |=> rsp_o.valid && rsp_o.data == 16'h0011;
  endproperty
  a_rev: assert property (p_rev) else $error("revision read");
  property p_status;
    req_i.rd && req_i.cmd == `CMD_COMM_MEM_STATUS |=> rsp_o.data[4] == $past(mem_fault_i)
      && rsp_o.data[1] == $past(comm_fault_i) && rsp_o.data[15:8] == 8'h00;
  endproperty
  a_status: assert property (p_status) else $error("status byte");
  property p_vin;
    req_i.rd && req_i.cmd == `CMD_INPUT_VOLTAGE |=> rsp_o.data == $past(input_voltage_i);
  endproperty
  a_vin: assert property (p_vin) else $error("input voltage");
  property p_ro_flag;
    req_i.wr && req_i.cmd == `CMD_PROTOCOL_REV ##1 req_i.rd && req_i.cmd == `CMD_COMM_MEM_STATUS
      |=> rsp_o.data[7];
  endproperty
  a_ro_flag: assert property (p_ro_flag) else $error("read-only write flag");
  property p_erase;
    nvm_erase_o |-> $past(req_i.wr && req_i.cmd == `CMD_NVM_ERASE) && nvm_addr_o == 8'h00;
  endproperty
  a_erase: assert property (p_erase) else $error("erase pulse");
  property p_nvm_wr;
    nvm_wr_o |-> $past(req_i.wr && req_i.cmd == `CMD_NVM_DATA)
      && nvm_wdata_o == $past(req_i.data) && nvm_addr_o == $past(nvm_addr_o) + 8'h01;
  endproperty
  a_nvm_wr: assert property (p_nvm_wr) else $error("memory write");
  property p_alt;
    req_i.wr && req_i.cmd == `CMD_ALT_COMMAND |=> alt_cmd_o == $past(req_i.data);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate command");
  property p_global;
    req_i.wr && req_i.cmd == `CMD_GLOBAL_CONFIG |=> global_config_o == $past(req_i.data);
  endproperty
  a_global: assert property (p_global) else $error("global config");
  property p_chan;
    req_i.wr && req_i.cmd == `CMD_CHANNEL_CONFIG && page_i < 8'h08 ##1 $stable(page_i)
      |-> channel_config_o == $past(req_i.data);
  endproperty
  a_chan: assert property (p_chan) else $error("channel config");
  property p_open_drain;
    shared_fault_pin_o == 4'h0
      && (&shared_fault_pin_oe_n_o[1:0] || $past(|faulted_off_i[3:0]))
      && (&shared_fault_pin_oe_n_o[3:2] || $past(|faulted_off_i[7:4]));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("fault pin level");
endmodule
bind pmbus_status_config_command_bank pmbus_bank_properties i_props (.clk_i, .reset_i,
  .req_i, .rsp_o, .page_i, .mem_fault_i, .comm_fault_i, .input_voltage_i, .nvm_addr_o,
  .nvm_wdata_o, .nvm_wr_o, .nvm_erase_o, .alt_cmd_o, .channel_config_o, .global_config_o,
  .shared_fault_pin_o, .faulted_off_i, .shared_fault_pin_oe_n_o);

// >>> bench/pmbus_nvm_model.sv
`timescale 1ns/1ps
module pmbus_nvm_model (
  input wire logic clk_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic erase_i,
  output logic [15:0] rdata_o
);
  // Cells stay unknown until the first erase or until a write to that cell
  logic [15:0] mem [256];
  assign rdata_o = mem[addr_i];
  always @(posedge clk_i) begin
    if (erase_i) begin
      for (int k = 0; k < 256; k++) begin
        mem[k] <= 16'hFFFF;
      end
    end else if (wr_i) begin
      // Address has already stepped past the word being written
      mem[addr_i - 8'h01] <= wdata_i;
    end
  end
endmodule

// >>> bench/pmbus_status_config_command_bank_tb.sv
`timescale 1ns/1ps
`include "pmbus_bank_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pmbus_status_config_command_bank_tb
  import pmbus_bank_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  bus_req_t req = '0;
  bus_rsp_t rsp_o;
  logic [7:0] page = 8'h00;
  logic clr = 1'b0, memf = 1'b0, commf = 1'b0, wdog = 1'b1;
  logic [`NUM_CHANNELS-1:0][7:0] vst;
  logic [`NUM_CHANNELS-1:0][15:0] xst, vout;
  logic [15:0] vin = 16'hD3C4, temp = 16'hE5A1, rdata;
  logic [7:0] foff = 8'h00, good = 8'hFF, addr;
  logic [15:0] wdata;
  logic nwr, nrd, nerase, pgood;
  logic [3:0] oe_n;
  logic [15:0] altc, gcfg, ccfg;
  int num_errors = 0;
  int total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  pmbus_status_config_command_bank i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req),
    .rsp_o(rsp_o), .page_i(page), .clear_faults_i(clr), .mem_fault_i(memf),
    .comm_fault_i(commf), .vendor_status_i(vst), .extra_status_i(xst),
    .output_voltage_i(vout), .input_voltage_i(vin), .die_temperature_i(temp),
    .vendor_info_i(16'h5A5A), .faulted_off_i(foff), .channel_good_i(good),
    .watchdog_ok_i(wdog), .nvm_rdata_i(rdata), .nvm_addr_o(addr), .nvm_wdata_o(wdata),
    .nvm_wr_o(nwr), .nvm_rd_o(nrd), .nvm_erase_o(nerase), .alt_cmd_o(altc),
    .channel_config_o(ccfg), .global_config_o(gcfg), .shared_fault_pin_o(),
    .shared_fault_pin_oe_n_o(oe_n), .power_good_output_o(pgood));
  pmbus_nvm_model i_nvm (.clk_i(clk_i), .addr_i(addr), .wdata_i(wdata), .wr_i(nwr),
    .erase_i(nerase), .rdata_o(rdata));
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Leaves the write strobe up so back-to-back requests need no idle cycle
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    req = '{1'b0, 1'b1, c, d, 5'h00};
    @(negedge clk_i);
  endtask
  task automatic idle();
    req = '0;
    @(negedge clk_i);
  endtask
  // Read strobe stays up too; a repeated read only steps the memory address on 0xBF
  task automatic rdc(input logic [7:0] c, input logic [15:0] e, input logic [4:0] i = 5'h00);
    req = '{1'b1, 1'b0, c, 16'h0000, i};
    @(negedge clk_i);
    `CHK("valid", 1'b1, rsp_o.valid)
    `CHK("rdata", e, rsp_o.data)
  endtask
  task automatic t_defaults();
    rdc(`CMD_PROTOCOL_REV, 16'h0011);
    rdc(`CMD_CHANNEL_CONFIG, 16'h0080);
    rdc(`CMD_GLOBAL_CONFIG, 16'h1C7B);
    rdc(`CMD_FAULT_EVEN_PROP, 16'h0000);
    rdc(`CMD_FAULT_ODD_PROP, 16'h0000);
    rdc(`CMD_POWER_GOOD_MAP, 16'h0000);
    rdc(`CMD_GLOBAL_PAGE_MASK, 16'h00FF);
    `CHK("oe_n", 4'hF, oe_n)
    `CHK("pgood", 1'b1, pgood)
  endtask
  task automatic t_telemetry();
    memf = 1'b1;
    commf = 1'b1;
    page = 8'h05;
    rdc(`CMD_COMM_MEM_STATUS, 16'h0012);
    commf = 1'b0;
    rdc(`CMD_COMM_MEM_STATUS, 16'h0010);
    rdc(`CMD_INPUT_VOLTAGE, vin);
    rdc(`CMD_DIE_TEMPERATURE, temp);
    rdc(`CMD_VENDOR_STATUS, {8'h00, vst[5]});
    rdc(`CMD_OUTPUT_VOLTAGE, vout[5]);
    rdc(`CMD_EXTRA_STATUS, xst[5]);
    rdc(`CMD_TELEMETRY, 16'h0010, 5'h00);
    rdc(`CMD_TELEMETRY, {8'h00, vout[1][7:0]}, 5'h03);
    rdc(`CMD_TELEMETRY, {8'h00, vout[7][15:8]}, 5'h10);
    rdc(`CMD_TELEMETRY, 16'h0000, 5'h11);
    memf = 1'b0;
  endtask
  task automatic t_refused();
    wr(`CMD_PROTOCOL_REV, 16'h0022);
    rdc(`CMD_COMM_MEM_STATUS, 16'h0080);
    rdc(`CMD_PROTOCOL_REV, 16'h0011);
    page = 8'h08;
    rdc(`CMD_CHANNEL_CONFIG, 16'h0000);
    page = 8'h00;
    rdc(`CMD_COMM_MEM_STATUS, 16'h00C0);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    rdc(`CMD_COMM_MEM_STATUS, 16'h0000);
  endtask
  task automatic t_nvm();
    wr(`CMD_NVM_ERASE, 16'h0001);
    `CHK("erase", 1'b0, nerase)
    wr(`CMD_NVM_UNLOCK, 16'h00A5);
    wr(`CMD_NVM_ERASE, 16'h0001);
    `CHK("erase", 1'b1, nerase)
    `CHK("addr", 8'h00, addr)
    idle();
    rdc(`CMD_NVM_DATA, 16'hFFFF);
    `CHK("nrd", 1'b1, nrd)
    rdc(`CMD_NVM_DATA, 16'hFFFF);
    `CHK("addr", 8'h02, addr)
    wr(`CMD_NVM_ERASE, 16'h0001);
    wr(`CMD_NVM_DATA, 16'h1234);
    wr(`CMD_NVM_DATA, 16'h5678);
    idle();
    `CHK("cell0", 16'h1234, i_nvm.mem[0])
    `CHK("cell1", 16'h5678, i_nvm.mem[1])
    wr(`CMD_NVM_UNLOCK, 16'h0000);
    wr(`CMD_NVM_DATA, 16'h9999);
    idle();
    `CHK("addr", 8'h02, addr)
  endtask
  task automatic t_alt();
    wr(`CMD_ALT_COMMAND, 16'h0C5A);
    `CHK("altc", 16'h0C5A, altc)
    wr(`CMD_ALT_HOST0, 16'h1111);
    wr(`CMD_ALT_HOST1, 16'h2222);
    rdc(`CMD_ALT_COMMAND, 16'h0C5A);
    rdc(`CMD_ALT_HOST0, 16'h1111);
    rdc(`CMD_ALT_HOST1, 16'h2222);
  endtask
  task automatic t_config();
    page = 8'h03;
    wr(`CMD_CHANNEL_CONFIG, 16'h1234);
    rdc(`CMD_CHANNEL_CONFIG, 16'h1234);
    `CHK("ccfg", 16'h1234, ccfg)
    page = 8'h04;
    rdc(`CMD_CHANNEL_CONFIG, 16'h0080);
    wr(`CMD_GLOBAL_CONFIG, 16'hA5C3);
    `CHK("gcfg", 16'hA5C3, gcfg)
    wr(`CMD_GLOBAL_PAGE_MASK, 16'h0001);
    page = 8'hFF;
    wr(`CMD_CHANNEL_CONFIG, 16'hBEEF);
    page = 8'h01;
    rdc(`CMD_CHANNEL_CONFIG, 16'h0080);
    page = 8'h00;
    rdc(`CMD_CHANNEL_CONFIG, 16'hBEEF);
  endtask
  task automatic t_pins();
    page = 8'h01;
    wr(`CMD_FAULT_EVEN_PROP, 16'h0001);
    page = 8'h05;
    wr(`CMD_FAULT_ODD_PROP, 16'h0001);
    wr(`CMD_POWER_GOOD_MAP, 16'h0104);
    idle();
    foff = 8'h22;
    good = 8'hFB;
    @(negedge clk_i);
    `CHK("oe_n", 4'h6, oe_n)
    `CHK("pgood", 1'b0, pgood)
    good = 8'hFF;
    @(negedge clk_i);
    `CHK("pgood", 1'b1, pgood)
    wdog = 1'b0;
    @(negedge clk_i);
    `CHK("pgood", 1'b0, pgood)
  endtask
  initial begin
    for (int k = 0; k < `NUM_CHANNELS; k++) begin
      vst[k] = 8'h40 + 8'(k);
      xst[k] = 16'h8001 << k;
      vout[k] = 16'h1357 + 16'(k) * 16'h0101;
    end
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    t_defaults();
    t_telemetry();
    t_refused();
    t_nvm();
    t_alt();
    t_config();
    t_pins();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule

// >>> rtl/pmbus_bank_defs.svh
`ifndef PMBUS_BANK_DEFS_SVH
`define PMBUS_BANK_DEFS_SVH

`define NUM_CHANNELS 8
`define NVM_ADDR_W 8
`define GLOBAL_PAGE 8'hFF

`define CMD_COMM_MEM_STATUS 8'h7E
`define CMD_VENDOR_STATUS 8'h80
`define CMD_INPUT_VOLTAGE 8'h88
`define CMD_OUTPUT_VOLTAGE 8'h8B
`define CMD_DIE_TEMPERATURE 8'h8D
`define CMD_PROTOCOL_REV 8'h98
`define CMD_USER_TOOL_A 8'hB0
`define CMD_USER_TOOL_B 8'hB1
`define CMD_USER_OEM 8'hB2
`define CMD_SCRATCH_PAGED 8'hB3
`define CMD_SCRATCH_GLOBAL 8'hB4
`define CMD_VENDOR_RES_A 8'hB5
`define CMD_VENDOR_INFO 8'hB6
`define CMD_EXTRA_STATUS 8'hB7
`define CMD_VENDOR_RES_B 8'hBC
`define CMD_NVM_UNLOCK 8'hBD
`define CMD_NVM_ERASE 8'hBE
`define CMD_NVM_DATA 8'hBF
`define CMD_ALT_COMMAND 8'hC0
`define CMD_ALT_HOST0 8'hC1
`define CMD_ALT_HOST1 8'hC2
`define CMD_TELEMETRY 8'hCF
`define CMD_CHANNEL_CONFIG 8'hD0
`define CMD_GLOBAL_CONFIG 8'hD1
`define CMD_FAULT_EVEN_PROP 8'hD2
`define CMD_FAULT_ODD_PROP 8'hD3
`define CMD_POWER_GOOD_MAP 8'hD4
`define CMD_GLOBAL_PAGE_MASK 8'hE4

`define PROTOCOL_REV_VALUE 8'h11
`define NVM_UNLOCK_KEY 8'hA5
`define RST_CHANNEL_CONFIG 16'h0080
`define RST_GLOBAL_CONFIG 16'h1C7B
`define RST_FAULT_PROP 8'h00
`define RST_POWER_GOOD_MAP 16'h0000
`define RST_SCRATCH 16'h0000
`define RST_PAGE_MASK 8'hFF

`define CML_BAD_CMD_BIT 7
`define CML_BAD_DATA_BIT 6
`define CML_MEM_FAULT_BIT 4
`define CML_COMM_FAULT_BIT 1
`define PG_MAP_WATCHDOG_BIT 8

`endif

// >>> rtl/pmbus_bank_pkg.sv
package pmbus_bank_pkg;
  `include "pmbus_bank_defs.svh"

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] cmd;
    logic [15:0] data;
    logic [4:0] blk_idx;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } bus_rsp_t;

  typedef struct packed {
    logic [15:0] user_tool_b;
    logic [15:0] scratch;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic [15:0] cfg;
    logic [7:0] prop_even;
    logic [7:0] prop_odd;
  } chan_regs_t;

  typedef struct packed {
    chan_regs_t [`NUM_CHANNELS-1:0] ch;
    logic [15:0] user_tool_a;
    logic [15:0] user_oem;
    logic [15:0] scratch_global;
    logic [15:0] alt_cmd;
    logic [15:0] alt_data0;
    logic [15:0] alt_data1;
    logic [15:0] global_cfg;
    logic [15:0] pg_map;
    logic [7:0] unlock;
    logic [7:0] erase;
    logic [7:0] page_mask;
    logic nvm_open;
    logic [`NVM_ADDR_W-1:0] nvm_addr;
    logic [15:0] nvm_wdata;
    logic nvm_wr;
    logic nvm_rd;
    logic nvm_erase;
    logic bad_cmd;
    logic bad_data;
    bus_rsp_t rsp;
    logic [3:0] fault_drive;
    logic power_good;
  } bank_state_t;
endpackage

// >>> rtl/pmbus_status_config_command_bank.sv
// Function
// - Non-paged comm and memory status byte
// - Paged vendor fault and state byte
// - Input-sense voltage word, linear11 format
// - Paged output voltage word, linear16 format
// - Junction temperature word, linear11 format
// - Protocol revision reads fixed 0x11
// - Paged extra vendor status word
// - Unlock byte gates erase and data
// - Erase byte prepares nonvolatile memory
// - Data word steps through memory sequentially
// - Shared alternate-access command word
// - Alternate data words for hosts 0, 1
// - Block read returns all channel telemetry
// - Paged channel config word, default 0x0080
// - Global config word, default 0x1C7B
// - Even propagate byte drives pins a, c
// - Odd propagate byte drives pins b, d
// - Power-good map selects combined pin sources
// - Global page writes honour page mask byte; global reads use channel 0
`timescale 1ns/1ps
`include "pmbus_bank_defs.svh"
module pmbus_status_config_command_bank
  import pmbus_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire bus_req_t req_i,
  output bus_rsp_t rsp_o,
  input wire logic [7:0] page_i,
  input wire logic clear_faults_i,
  input wire logic mem_fault_i,
  input wire logic comm_fault_i,
  input wire logic [`NUM_CHANNELS-1:0][7:0] vendor_status_i,
  input wire logic [`NUM_CHANNELS-1:0][15:0] extra_status_i,
  input wire logic [`NUM_CHANNELS-1:0][15:0] output_voltage_i,
  input wire logic [15:0] input_voltage_i,
  input wire logic [15:0] die_temperature_i,
  input wire logic [15:0] vendor_info_i,
  input wire logic [`NUM_CHANNELS-1:0] faulted_off_i,
  input wire logic [`NUM_CHANNELS-1:0] channel_good_i,
  input wire logic watchdog_ok_i,
  input wire logic [15:0] nvm_rdata_i,
  output logic [`NVM_ADDR_W-1:0] nvm_addr_o,
  output logic [15:0] nvm_wdata_o,
  output logic nvm_wr_o,
  output logic nvm_rd_o,
  output logic nvm_erase_o,
  output logic [15:0] alt_cmd_o,
  output logic [15:0] channel_config_o,
  output logic [15:0] global_config_o,
  output logic [3:0] shared_fault_pin_o,
  output logic [3:0] shared_fault_pin_oe_n_o,
  output logic power_good_output_o
);

  localparam int NCH = `NUM_CHANNELS;
  localparam int HALF = NCH / 2;

  bank_state_t state_ff;
  bank_state_t nxt_state;

  logic page_is_global;
  logic page_valid;
  logic [2:0] sel_ch;
  logic [NCH-1:0] write_hit;
  logic [NCH-1:0] even_a_term;
  logic [NCH-1:0] even_c_term;
  logic [NCH-1:0] odd_b_term;
  logic [NCH-1:0] odd_d_term;
  logic [NCH-1:0] pg_term;
  logic [3:0] fault_drive;
  logic pg_level;

  assign page_is_global = (page_i == `GLOBAL_PAGE);
  assign page_valid = page_is_global || (page_i < 8'(NCH));
  // Reads under the global page come from channel 0
  assign sel_ch = page_is_global ? 3'h0 : page_i[2:0];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // Global page writes reach only masked-in channels
      assign write_hit[gi] = page_is_global ? state_ff.page_mask[gi] :
        (page_valid && (sel_ch == 3'(gi)));
      if (gi < HALF) begin : g_lo
        assign even_a_term[gi] = faulted_off_i[gi] && state_ff.ch[gi].prop_even[0];
        assign even_c_term[gi] = 1'b0;
        assign odd_b_term[gi] = faulted_off_i[gi] && state_ff.ch[gi].prop_odd[0];
        assign odd_d_term[gi] = 1'b0;
      end else begin : g_hi
        assign even_a_term[gi] = 1'b0;
        assign even_c_term[gi] = faulted_off_i[gi] && state_ff.ch[gi].prop_even[0];
        assign odd_b_term[gi] = 1'b0;
        assign odd_d_term[gi] = faulted_off_i[gi] && state_ff.ch[gi].prop_odd[0];
      end
      // Unselected channels never hold power good low
      assign pg_term[gi] = !state_ff.pg_map[gi] || channel_good_i[gi];
    end
  endgenerate

  assign fault_drive = {|odd_d_term, |even_c_term, |odd_b_term, |even_a_term};
  assign pg_level = (&pg_term) &&
    (!state_ff.pg_map[`PG_MAP_WATCHDOG_BIT] || watchdog_ok_i);

  function automatic logic [7:0] telemetry_byte(input logic [4:0] idx,
                                                input logic [NCH-1:0][15:0] vout);
    logic [4:0] pos;
    logic [3:0] ch;
    pos = 5'h00;
    ch = 4'h0;
    telemetry_byte = 8'h00;
    if (idx == 5'h00) begin
      // First byte is the block byte count
      telemetry_byte = 8'(2 * NCH);
    end else if (idx <= 5'(2 * NCH)) begin
      pos = idx - 5'h01;
      ch = pos[4:1];
      telemetry_byte = pos[0] ? vout[ch[2:0]][15:8] : vout[ch[2:0]][7:0];
    end
  endfunction

  always_comb begin
    logic [15:0] rd_val;
    logic known;
    logic read_only;
    logic paged;
    logic [7:0] wbyte;
    rd_val = 16'h0000;
    known = 1'b1;
    read_only = 1'b0;
    paged = 1'b0;
    wbyte = req_i.data[7:0];
    nxt_state = state_ff;
    nxt_state.rsp.valid = 1'b0;
    nxt_state.nvm_wr = 1'b0;
    nxt_state.nvm_rd = 1'b0;
    nxt_state.nvm_erase = 1'b0;
    nxt_state.fault_drive = fault_drive;
    nxt_state.power_good = pg_level;
    if (clear_faults_i) begin
      nxt_state.bad_cmd = 1'b0;
      nxt_state.bad_data = 1'b0;
    end

    if (req_i.cmd == `CMD_COMM_MEM_STATUS) begin
      read_only = 1'b1;
      rd_val[`CML_BAD_CMD_BIT] = state_ff.bad_cmd;
      rd_val[`CML_BAD_DATA_BIT] = state_ff.bad_data;
      rd_val[`CML_MEM_FAULT_BIT] = mem_fault_i;
      rd_val[`CML_COMM_FAULT_BIT] = comm_fault_i;
    end else if (req_i.cmd == `CMD_VENDOR_STATUS) begin
      read_only = 1'b1;
      paged = 1'b1;
      rd_val = {8'h00, vendor_status_i[sel_ch]};
    end else if (req_i.cmd == `CMD_INPUT_VOLTAGE) begin
      read_only = 1'b1;
      rd_val = input_voltage_i;
    end else if (req_i.cmd == `CMD_OUTPUT_VOLTAGE) begin
      read_only = 1'b1;
      paged = 1'b1;
      rd_val = output_voltage_i[sel_ch];
    end else if (req_i.cmd == `CMD_DIE_TEMPERATURE) begin
      read_only = 1'b1;
      rd_val = die_temperature_i;
    end else if (req_i.cmd == `CMD_PROTOCOL_REV) begin
      read_only = 1'b1;
      rd_val = {8'h00, `PROTOCOL_REV_VALUE};
    end else if (req_i.cmd == `CMD_USER_TOOL_A) begin
      rd_val = state_ff.user_tool_a;
    end else if (req_i.cmd == `CMD_USER_TOOL_B) begin
      paged = 1'b1;
      rd_val = state_ff.ch[sel_ch].user_tool_b;
    end else if (req_i.cmd == `CMD_USER_OEM) begin
      rd_val = state_ff.user_oem;
    end else if (req_i.cmd == `CMD_SCRATCH_PAGED) begin
      paged = 1'b1;
      rd_val = state_ff.ch[sel_ch].scratch;
    end else if (req_i.cmd == `CMD_SCRATCH_GLOBAL) begin
      rd_val = state_ff.scratch_global;
    end else if (req_i.cmd == `CMD_VENDOR_RES_A) begin
      paged = 1'b1;
      rd_val = state_ff.ch[sel_ch].res_a;
    end else if (req_i.cmd == `CMD_VENDOR_INFO) begin
      read_only = 1'b1;
      rd_val = vendor_info_i;
    end else if (req_i.cmd == `CMD_EXTRA_STATUS) begin
      read_only = 1'b1;
      paged = 1'b1;
      rd_val = extra_status_i[sel_ch];
    end else if (req_i.cmd == `CMD_VENDOR_RES_B) begin
      paged = 1'b1;
      rd_val = state_ff.ch[sel_ch].res_b;
    end else if (req_i.cmd == `CMD_NVM_UNLOCK) begin
      rd_val = {8'h00, state_ff.unlock};
    end else if (req_i.cmd == `CMD_NVM_ERASE) begin
      rd_val = {8'h00, state_ff.erase};
    end else if (req_i.cmd == `CMD_NVM_DATA) begin
      // Memory read is combinational at the current address
      rd_val = nvm_rdata_i;
    end else if (req_i.cmd == `CMD_ALT_COMMAND) begin
      rd_val = state_ff.alt_cmd;
    end else if (req_i.cmd == `CMD_ALT_HOST0) begin
      rd_val = state_ff.alt_data0;
    end else if (req_i.cmd == `CMD_ALT_HOST1) begin
      rd_val = state_ff.alt_data1;
    end else if (req_i.cmd == `CMD_TELEMETRY) begin
      read_only = 1'b1;
      rd_val = {8'h00, telemetry_byte(req_i.blk_idx, output_voltage_i)};
    end else if (req_i.cmd == `CMD_CHANNEL_CONFIG) begin
      paged = 1'b1;
      rd_val = state_ff.ch[sel_ch].cfg;
    end else if (req_i.cmd == `CMD_GLOBAL_CONFIG) begin
      rd_val = state_ff.global_cfg;
    end else if (req_i.cmd == `CMD_FAULT_EVEN_PROP) begin
      paged = 1'b1;
      rd_val = {8'h00, state_ff.ch[sel_ch].prop_even};
    end else if (req_i.cmd == `CMD_FAULT_ODD_PROP) begin
      paged = 1'b1;
      rd_val = {8'h00, state_ff.ch[sel_ch].prop_odd};
    end else if (req_i.cmd == `CMD_POWER_GOOD_MAP) begin
      rd_val = state_ff.pg_map;
    end else if (req_i.cmd == `CMD_GLOBAL_PAGE_MASK) begin
      rd_val = {8'h00, state_ff.page_mask};
    end else begin
      known = 1'b0;
    end

    if (req_i.rd) begin
      nxt_state.rsp.valid = 1'b1;
      nxt_state.rsp.data = (known && (!paged || page_valid)) ? rd_val : 16'h0000;
      if (!known) begin
        nxt_state.bad_cmd = 1'b1;
      end else if (paged && !page_valid) begin
        nxt_state.bad_data = 1'b1;
      end else if (req_i.cmd == `CMD_NVM_DATA) begin
        if (state_ff.nvm_open) begin
          nxt_state.nvm_rd = 1'b1;
          nxt_state.nvm_addr = state_ff.nvm_addr + 1'b1;
        end else begin
          // Locked memory reads as zero
          nxt_state.rsp.data = 16'h0000;
          nxt_state.bad_data = 1'b1;
        end
      end
    end

    if (req_i.wr) begin
      if (!known || read_only) begin
        // State stays put; only the invalid flag records it
        nxt_state.bad_cmd = 1'b1;
      end else if (paged && !page_valid) begin
        nxt_state.bad_data = 1'b1;
      end else if (paged) begin
        for (int i = 0; i < NCH; i++) begin
          if (write_hit[i]) begin
            if (req_i.cmd == `CMD_USER_TOOL_B) begin
              nxt_state.ch[i].user_tool_b = req_i.data;
            end else if (req_i.cmd == `CMD_SCRATCH_PAGED) begin
              nxt_state.ch[i].scratch = req_i.data;
            end else if (req_i.cmd == `CMD_VENDOR_RES_A) begin
              nxt_state.ch[i].res_a = req_i.data;
            end else if (req_i.cmd == `CMD_VENDOR_RES_B) begin
              nxt_state.ch[i].res_b = req_i.data;
            end else if (req_i.cmd == `CMD_CHANNEL_CONFIG) begin
              nxt_state.ch[i].cfg = req_i.data;
            end else if (req_i.cmd == `CMD_FAULT_EVEN_PROP) begin
              nxt_state.ch[i].prop_even = wbyte;
            end else begin
              nxt_state.ch[i].prop_odd = wbyte;
            end
          end
        end
      end else if (req_i.cmd == `CMD_USER_TOOL_A) begin
        nxt_state.user_tool_a = req_i.data;
      end else if (req_i.cmd == `CMD_USER_OEM) begin
        nxt_state.user_oem = req_i.data;
      end else if (req_i.cmd == `CMD_SCRATCH_GLOBAL) begin
        nxt_state.scratch_global = req_i.data;
      end else if (req_i.cmd == `CMD_NVM_UNLOCK) begin
        nxt_state.unlock = wbyte;
        // Any other value locks again
        nxt_state.nvm_open = (wbyte == `NVM_UNLOCK_KEY);
      end else if (req_i.cmd == `CMD_NVM_ERASE) begin
        if (state_ff.nvm_open) begin
          nxt_state.erase = wbyte;
          nxt_state.nvm_erase = 1'b1;
          nxt_state.nvm_addr = '0;
        end else begin
          nxt_state.bad_data = 1'b1;
        end
      end else if (req_i.cmd == `CMD_NVM_DATA) begin
        if (state_ff.nvm_open) begin
          nxt_state.nvm_wr = 1'b1;
          nxt_state.nvm_wdata = req_i.data;
          nxt_state.nvm_addr = state_ff.nvm_addr + 1'b1;
        end else begin
          nxt_state.bad_data = 1'b1;
        end
      end else if (req_i.cmd == `CMD_ALT_COMMAND) begin
        nxt_state.alt_cmd = req_i.data;
      end else if (req_i.cmd == `CMD_ALT_HOST0) begin
        nxt_state.alt_data0 = req_i.data;
      end else if (req_i.cmd == `CMD_ALT_HOST1) begin
        nxt_state.alt_data1 = req_i.data;
      end else if (req_i.cmd == `CMD_GLOBAL_CONFIG) begin
        nxt_state.global_cfg = req_i.data;
      end else if (req_i.cmd == `CMD_POWER_GOOD_MAP) begin
        nxt_state.pg_map = req_i.data;
      end else begin
        nxt_state.page_mask = wbyte;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        state_ff.ch[i].scratch <= `RST_SCRATCH;
        state_ff.ch[i].cfg <= `RST_CHANNEL_CONFIG;
        state_ff.ch[i].prop_even <= `RST_FAULT_PROP;
        state_ff.ch[i].prop_odd <= `RST_FAULT_PROP;
      end
      state_ff.scratch_global <= `RST_SCRATCH;
      state_ff.global_cfg <= `RST_GLOBAL_CONFIG;
      state_ff.pg_map <= `RST_POWER_GOOD_MAP;
      state_ff.page_mask <= `RST_PAGE_MASK;
      // Power good stays low until the first evaluated cycle
      state_ff.power_good <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rsp_o = state_ff.rsp;
  assign nvm_addr_o = state_ff.nvm_addr;
  assign nvm_wdata_o = state_ff.nvm_wdata;
  assign nvm_wr_o = state_ff.nvm_wr;
  assign nvm_rd_o = state_ff.nvm_rd;
  assign nvm_erase_o = state_ff.nvm_erase;
  assign alt_cmd_o = state_ff.alt_cmd;
  assign channel_config_o = state_ff.ch[sel_ch].cfg;
  assign global_config_o = state_ff.global_cfg;
  // Open-drain pins only ever pull low
  assign shared_fault_pin_o = 4'h0;
  assign shared_fault_pin_oe_n_o = ~state_ff.fault_drive;
  assign power_good_output_o = state_ff.power_good;

endmodule
